// ### logic/pfs_defines.svh
// Constants of the power supply fault supervisor: timings, offsets, field positions
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

`define PFS_CLK_MHZ 100
`define PFS_T_OV_US 6
`define PFS_T_UV12_US 6
`define PFS_T_UV5_US 450
`define PFS_T_OC_US 450
`define PFS_T_AUXOV_US 6
`define PFS_T_AUXUV_US 500
`define PFS_T_PG_MS 250
`define PFS_T_AUXEN_MS 64
`define PFS_T_RETRY_S 1
`define PFS_US2CYC(t) ((t) * `PFS_CLK_MHZ)
`define PFS_MS2CYC(t) ((t) * 1000 * `PFS_CLK_MHZ)
`define PFS_S2CYC(t) ((t) * 1000000 * `PFS_CLK_MHZ)
`define PFS_PON_DEB_CYC 200000
`define PFS_WARN_CYC 100000
`define PFS_MAIN_BLANK_CYC 1000000
`define PFS_AUX_BLANK_CYC 1000000

`define PFS_OFS_CTRL 4'h0
`define PFS_OFS_STATUS 4'h4
`define PFS_OFS_INT_STAT 4'h8
`define PFS_OFS_INT_MASK 4'hc

`define PFS_CTRL_W 5
`define PFS_CTRL_RST 5'h00
`define PFS_CTRL_BOUNCE 0
`define PFS_CTRL_OV12_DIS 1
`define PFS_CTRL_OV5_DIS 2
`define PFS_CTRL_AUX_3V3 3
`define PFS_CTRL_OCP_3V3 4

`define PFS_EV_W 6
`define PFS_EV_RST 6'h00
`define PFS_EV_OV 0
`define PFS_EV_UVOC 1
`define PFS_EV_AUX_OV 2
`define PFS_EV_AUX_UV 3
`define PFS_EV_PG_RISE 4
`define PFS_EV_PG_FALL 5

`define PFS_RAIL_P5 1
`define PFS_RAIL_P12 3
`define PFS_RAIL_12_FIRST 3
`define PFS_CMP_RST 19'h00001

`endif

// ### logic/pfs_pkg.sv
// Types shared by the power supply fault supervisor
package pfs_pkg;
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_BLANK = 3'h1,
      ST_RUN = 3'h3,
      ST_WARN = 3'h2,
      ST_FAULT = 3'h6,
      ST_RETRY = 3'h7
   } pfs_state_e;

   // Rails: 0 3.3V, 1 +5V, 2 -5V, 3 +12V, 4 -12V
   typedef struct packed {
      logic [4:0] uv;
      logic [4:0] ov;
      logic oc_12v;
      logic oc_5v;
      logic oc_3v3;
      logic aux_uv;
      logic aux_ov;
      logic mains_ok;
      logic power_on_request;
      logic supply_undervoltage_lockout;
   } pfs_cmp_s;

   typedef logic [3:0] pfs_addr_t;
endpackage

// ### logic/pfs_supervisor.sv
// Power supply fault supervisor and power-good sequencer
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_supervisor import pfs_pkg::*; #(
   parameter int unsigned P_UV5_CYC = `PFS_US2CYC(`PFS_T_UV5_US),
   parameter int unsigned P_OC_CYC = `PFS_US2CYC(`PFS_T_OC_US),
   parameter int unsigned P_AUXUV_CYC = `PFS_US2CYC(`PFS_T_AUXUV_US),
   parameter int unsigned P_PG_CYC = `PFS_MS2CYC(`PFS_T_PG_MS),
   parameter int unsigned P_AUXEN_CYC = `PFS_MS2CYC(`PFS_T_AUXEN_MS),
   parameter int unsigned P_RETRY_CYC = `PFS_S2CYC(`PFS_T_RETRY_S),
   parameter int unsigned P_PON_DEB_CYC = `PFS_PON_DEB_CYC,
   parameter int unsigned P_WARN_CYC = `PFS_WARN_CYC,
   parameter int unsigned P_MAIN_BLANK_CYC = `PFS_MAIN_BLANK_CYC,
   parameter int unsigned P_AUX_BLANK_CYC = `PFS_AUX_BLANK_CYC
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   input wire pfs_cmp_s cmp_in,
   input wire pfs_addr_t addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rd_data,
   output logic main_fault,
   output logic aux_fault,
   output logic aux_duty_pulldown,
   output logic power_good,
   output logic aux_thr_3v3,
   output logic irq
);
   localparam logic [31:0] OV_CYC = 32'(`PFS_US2CYC(`PFS_T_OV_US));
   localparam logic [31:0] UV12_CYC = 32'(`PFS_US2CYC(`PFS_T_UV12_US));
   localparam logic [31:0] AUXOV_CYC = 32'(`PFS_US2CYC(`PFS_T_AUXOV_US));

   pfs_cmp_s meta_reg;
   pfs_cmp_s cmp_s;
   pfs_state_e state_reg;
   pfs_state_e state_next;
   logic [`PFS_CTRL_W-1:0] ctrl_reg;
   logic [`PFS_CTRL_W-1:0] ctrl_next;
   logic [`PFS_EV_W-1:0] int_stat_reg;
   logic [`PFS_EV_W-1:0] int_stat_next;
   logic [`PFS_EV_W-1:0] int_mask_reg;
   logic [`PFS_EV_W-1:0] int_mask_next;
   logic [`PFS_EV_W-1:0] ev;
   logic pon_stable_reg;
   logic pon_stable_next;
   logic main_fault_next;
   logic aux_fault_next;
   logic power_good_next;
   logic [31:0] rd_word;
   logic [4:0] ov_mask;
   logic [4:0] uv_q;
   logic supply_undervoltage_lockout_s;
   logic mains_ok_s;
   logic ov_q;
   logic oc_mon;
   logic oc_q;
   logic uvoc_q;
   logic aux_ov_q;
   logic aux_uv_q;
   logic aux_en_done;
   logic aux_blank_done;
   logic deb_done;
   logic blank_done;
   logic pg_done;
   logic retry_done;
   logic warn_done;
   logic main_live;
   logic main_halt;
   logic hit_ctrl;
   logic hit_status;
   logic hit_istat;
   logic hit_imask;

   // Analog comparator results are asynchronous to mclk
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= pfs_cmp_s'(`PFS_CMP_RST);
         cmp_s <= pfs_cmp_s'(`PFS_CMP_RST);
      end else if (ce) begin
         meta_reg <= cmp_in;
         cmp_s <= meta_reg;
      end
   end

   assign supply_undervoltage_lockout_s = cmp_s.supply_undervoltage_lockout;
   assign mains_ok_s = cmp_s.mains_ok;

   // Power request debounce
   pfs_timer u_deb (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(cmp_s.power_on_request != pon_stable_reg),
      .limit(P_PON_DEB_CYC),
      .done(deb_done)
   );
   assign pon_stable_next = supply_undervoltage_lockout_s ? 1'b0 : (deb_done ? cmp_s.power_on_request : pon_stable_reg);

   // Over-voltage, never blanked
   assign ov_mask[0] = 1'b0;
   assign ov_mask[`PFS_RAIL_P5] = ctrl_reg[`PFS_CTRL_OV5_DIS];
   assign ov_mask[2] = 1'b0;
   assign ov_mask[`PFS_RAIL_P12] = ctrl_reg[`PFS_CTRL_OV12_DIS];
   assign ov_mask[4] = 1'b0;
   pfs_timer u_ov (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(|(cmp_s.ov & ~ov_mask)),
      .limit(OV_CYC),
      .done(ov_q)
   );

   // Per-rail under-voltage persistence; 12V rails are fast
   for (genvar i = 0; i < 5; i++) begin : g_uv
      pfs_timer u_uv (
         .mclk(mclk),
         .arst_n(arst_n),
         .ce(ce),
         .clr(supply_undervoltage_lockout_s),
         .run(cmp_s.uv[i]),
         .limit((i >= `PFS_RAIL_12_FIRST) ? UV12_CYC : P_UV5_CYC),
         .done(uv_q[i])
      );
   end

   assign oc_mon = cmp_s.oc_12v | (ctrl_reg[`PFS_CTRL_OCP_3V3] ? cmp_s.oc_3v3 : cmp_s.oc_5v);
   pfs_timer u_oc (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(oc_mon),
      .limit(P_OC_CYC),
      .done(oc_q)
   );
   assign uvoc_q = (|uv_q) | oc_q;

   // Auxiliary rail
   pfs_timer u_aux_ov (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(cmp_s.aux_ov),
      .limit(AUXOV_CYC),
      .done(aux_ov_q)
   );
   pfs_timer u_aux_en (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(!supply_undervoltage_lockout_s),
      .limit(P_AUXEN_CYC),
      .done(aux_en_done)
   );
   pfs_timer u_aux_blank (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(!supply_undervoltage_lockout_s),
      .limit(P_AUX_BLANK_CYC),
      .done(aux_blank_done)
   );
   // Gating the run input keeps persistence from counting while blanked
   pfs_timer u_aux_uv (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(cmp_s.aux_uv && aux_en_done && aux_blank_done),
      .limit(P_AUXUV_CYC),
      .done(aux_uv_q)
   );

   // Sequencing timers
   pfs_timer u_blank (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(state_reg == ST_BLANK),
      .limit(P_MAIN_BLANK_CYC),
      .done(blank_done)
   );
   pfs_timer u_pg (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(state_reg == ST_RUN && !(|cmp_s.uv) && mains_ok_s),
      .limit(P_PG_CYC),
      .done(pg_done)
   );
   pfs_timer u_retry (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(state_reg == ST_RETRY),
      .limit(P_RETRY_CYC),
      .done(retry_done)
   );
   pfs_timer u_warn (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .clr(supply_undervoltage_lockout_s),
      .run(state_reg == ST_WARN),
      .limit(P_WARN_CYC),
      .done(warn_done)
   );

   assign main_live = (state_reg == ST_BLANK) || (state_reg == ST_RUN) || (state_reg == ST_WARN);
   assign main_halt = aux_uv_q || aux_fault;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (pon_stable_reg && !main_halt) begin
               state_next = ST_BLANK;
            end
         end
         ST_BLANK: begin
            if (ov_q) begin
               state_next = ST_FAULT;
            end else if (main_halt) begin
               state_next = ST_OFF;
            end else if (!pon_stable_reg) begin
               state_next = ST_WARN;
            end else if (blank_done) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ov_q) begin
               state_next = ST_FAULT;
            end else if (main_halt) begin
               state_next = ST_OFF;
            end else if (!pon_stable_reg) begin
               state_next = ST_WARN;
            end else if (uvoc_q) begin
               state_next = ctrl_reg[`PFS_CTRL_BOUNCE] ? ST_RETRY : ST_FAULT;
            end
         end
         ST_WARN: begin
            if (ov_q) begin
               state_next = ST_FAULT;
            end else if (warn_done) begin
               state_next = ST_OFF;
            end
         end
         ST_FAULT: begin
            if (!pon_stable_reg) begin
               state_next = ST_OFF;
            end
         end
         ST_RETRY: begin
            if (retry_done) begin
               state_next = ST_OFF;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
      if (supply_undervoltage_lockout_s) begin
         state_next = ST_OFF;
      end
   end

   assign aux_fault_next = !supply_undervoltage_lockout_s && (aux_fault || aux_ov_q);
   assign main_fault_next = !main_live || aux_fault || aux_uv_q;
   assign power_good_next = (state_reg == ST_RUN) && pg_done && mains_ok_s && pon_stable_reg
      && !main_halt && !ov_q && !uvoc_q;

   // Events for the interrupt status
   assign ev[`PFS_EV_OV] = ov_q && main_live && (state_next == ST_FAULT);
   assign ev[`PFS_EV_UVOC] = !ov_q && (state_reg == ST_RUN)
      && ((state_next == ST_FAULT) || (state_next == ST_RETRY));
   assign ev[`PFS_EV_AUX_OV] = aux_fault_next && !aux_fault;
   assign ev[`PFS_EV_AUX_UV] = aux_uv_q && !aux_duty_pulldown;
   assign ev[`PFS_EV_PG_RISE] = power_good_next && !power_good;
   assign ev[`PFS_EV_PG_FALL] = !power_good_next && power_good;

   // Register port
   assign hit_ctrl = (addr == `PFS_OFS_CTRL);
   assign hit_status = (addr == `PFS_OFS_STATUS);
   assign hit_istat = (addr == `PFS_OFS_INT_STAT);
   assign hit_imask = (addr == `PFS_OFS_INT_MASK);
   assign ctrl_next = (wr_stb && hit_ctrl) ? wr_data[`PFS_CTRL_W-1:0] : ctrl_reg;
   assign int_mask_next = (wr_stb && hit_imask) ? wr_data[`PFS_EV_W-1:0] : int_mask_reg;
   // An event in the clearing read's cycle survives the clear
   assign int_stat_next = (int_stat_reg & ~{`PFS_EV_W{rd_stb && hit_istat}}) | ev;
   assign rd_word = hit_ctrl ? {27'h0, ctrl_reg}
      : hit_status ? {23'h0, state_reg, pon_stable_reg, mains_ok_s, aux_duty_pulldown,
                      aux_fault, main_fault, power_good}
      : hit_istat ? {26'h0, int_stat_reg}
      : hit_imask ? {26'h0, int_mask_reg}
      : 32'h0;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_OFF;
         pon_stable_reg <= 1'b0;
         main_fault <= 1'b1;
         aux_fault <= 1'b0;
         aux_duty_pulldown <= 1'b0;
         power_good <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         pon_stable_reg <= pon_stable_next;
         main_fault <= main_fault_next;
         aux_fault <= aux_fault_next;
         aux_duty_pulldown <= aux_uv_q;
         power_good <= power_good_next;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `PFS_CTRL_RST;
         int_stat_reg <= `PFS_EV_RST;
         int_mask_reg <= `PFS_EV_RST;
         rd_data <= 32'h0;
         irq <= 1'b0;
      end else if (ce) begin
         ctrl_reg <= ctrl_next;
         int_stat_reg <= int_stat_next;
         int_mask_reg <= int_mask_next;
         rd_data <= rd_stb ? rd_word : 32'h0;
         irq <= |(int_stat_reg & int_mask_reg);
      end
   end

   assign aux_thr_3v3 = ctrl_reg[`PFS_CTRL_AUX_3V3];

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n || !ce || supply_undervoltage_lockout_s);

   a_ov_latch_fault: assert property (ov_q && main_live |-> ##2 (main_fault && !power_good))
      else $error("over-voltage did not latch main fault");
   a_ov_fault_hold: assert property (state_reg == ST_FAULT && pon_stable_reg |=> state_reg == ST_FAULT)
      else $error("latched fault released without power request cycle");
   a_bounce_retry: assert property (state_reg == ST_RETRY && retry_done |=> state_reg == ST_OFF)
      else $error("bounce retry did not restart");
   a_uvoc_mode: assert property (state_reg == ST_RUN && uvoc_q && !ov_q && !main_halt && pon_stable_reg
      |=> state_reg == (ctrl_reg[`PFS_CTRL_BOUNCE] ? ST_RETRY : ST_FAULT))
      else $error("under-voltage or over-current took wrong mode");
   a_pg_delay: assert property ($rose(power_good) |-> $past(pg_done) && $past(mains_ok_s))
      else $error("power good rose before delay");
   a_aux_ov_hold: assert property (aux_fault |=> aux_fault && main_fault)
      else $error("aux over-voltage latch lost");
   a_aux_uv_pull: assert property (aux_uv_q |=> aux_duty_pulldown && main_fault && !power_good)
      else $error("aux under-voltage response missing");
   a_aux_uv_enable: assert property (!aux_en_done || !aux_blank_done |-> !aux_uv_q)
      else $error("aux under-voltage seen while disabled");
   a_uv_blanking: assert property (state_reg == ST_BLANK && !ov_q |=> state_reg != ST_FAULT
      && state_reg != ST_RETRY)
      else $error("blanked fault reached main fault");
   a_pon_debounce: assert property (pon_stable_reg != $past(pon_stable_reg) |-> $past(deb_done)
      || $past(supply_undervoltage_lockout_s))
      else $error("power request changed without debounce");
   a_poweroff_warn: assert property (state_reg == ST_WARN && !main_halt |=> !main_fault && !power_good)
      else $error("power-off warning order wrong");
   a_mains_pg: assert property (!mains_ok_s |=> !power_good)
      else $error("power good high with mains fault");

   c_pg_rise: cover property ($rose(power_good));
   c_retry: cover property (state_reg == ST_RUN ##1 state_reg == ST_RETRY);
   c_aux_ov: cover property ($rose(aux_fault));
   c_warn_off: cover property (state_reg == ST_WARN ##1 state_reg == ST_OFF);
endmodule // pfs_supervisor

// ### logic/pfs_timer.sv
// Persistence timer: counts while run is high, saturates at the limit
`timescale 1ns/1ps
module pfs_timer (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic clr,
   input wire logic run,
   input wire logic [31:0] limit,
   output logic done
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;

   assign done = (cnt_reg >= limit);
   // Any drop of run restarts the count, so only an unbroken level qualifies
   assign cnt_next = (clr || !run) ? 32'h0 : (done ? cnt_reg : cnt_reg + 32'h1);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 32'h0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end
endmodule // pfs_timer

// ### sim/pfs_rail_model.sv
// Behavioural main converter: rails sag while stopped, ramp after start
`timescale 1ns/1ps
module pfs_rail_model #(
   parameter int RAMP_CYC = 20
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic main_fault,
   output logic [4:0] rail_uv
);
   int ramp_reg;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ramp_reg <= 0;
      end else if (main_fault) begin
         ramp_reg <= 0;
      end else if (ramp_reg < RAMP_CYC) begin
         ramp_reg <= ramp_reg + 1;
      end
   end

   // Rails read low through the ramp, so start-up blanking really matters
   assign rail_uv = (ramp_reg < RAMP_CYC) ? 5'h1f : 5'h00;
endmodule // pfs_rail_model

// ### sim/psu_fault_supervisor_tb.sv
// Self-checking bench for the power supply fault supervisor
`timescale 1ns/1ps
module psu_fault_supervisor_tb import pfs_pkg::*; ;
   localparam int MF = 0, AF = 1, DP = 2, PG = 3, TH = 4, IQ = 5;
   localparam int unsigned K_UV5 = 40, K_OC = 40, K_AUXUV = 50, K_PG = 100, K_AUXEN = 60;
   localparam int unsigned K_RETRY = 300, K_DEB = 20, K_WARN = 30, K_MBLANK = 700, K_ABLANK = 40;
   logic mclk, arst_n, wr_stb, rd_stb, ce;
   pfs_cmp_s cmp, cmp_in;
   pfs_addr_t addr;
   logic [31:0] wr_data, rd_data;
   logic main_fault, aux_fault, aux_duty_pulldown, power_good, aux_thr_3v3, irq;
   logic [4:0] rail_uv;
   logic [5:0] outs;
   int miscompares = 0;
   int n_compared = 0;

   always_comb begin
      cmp_in = cmp;
      cmp_in.uv = cmp.uv | rail_uv;
   end
   assign outs = {irq, aux_thr_3v3, power_good, aux_duty_pulldown, aux_fault, main_fault};

   // Short counts keep the run small; main blanking outlasts the 600-cycle OV delay
   pfs_supervisor #(.P_UV5_CYC(K_UV5), .P_OC_CYC(K_OC), .P_AUXUV_CYC(K_AUXUV), .P_PG_CYC(K_PG),
      .P_AUXEN_CYC(K_AUXEN), .P_RETRY_CYC(K_RETRY), .P_PON_DEB_CYC(K_DEB), .P_WARN_CYC(K_WARN),
      .P_MAIN_BLANK_CYC(K_MBLANK), .P_AUX_BLANK_CYC(K_ABLANK)) dut_u (
      .mclk(mclk), .arst_n(arst_n), .ce(ce), .cmp_in(cmp_in), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .main_fault(main_fault), .aux_fault(aux_fault), .aux_duty_pulldown(aux_duty_pulldown),
      .power_good(power_good), .aux_thr_3v3(aux_thr_3v3), .irq(irq));

   pfs_rail_model rail_u (.mclk(mclk), .arst_n(arst_n), .main_fault(main_fault), .rail_uv(rail_uv));

   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wt(int b, logic v, int lim);
      int i;
      i = 0;
      while (i < lim && outs[b] !== v) begin
         @(posedge mclk);
         #1;
         i++;
      end
      chk($sformatf("out%0d", b), outs[b], v);
   endtask

   task automatic wr(pfs_addr_t a, logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(pfs_addr_t a, logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 chk("rd_data", rd_data, e);
   endtask

   // Long low phase so the old run is surely torn down before restart
   task automatic restart();
      @(posedge mclk) cmp.power_on_request <= 1'b0;
      cyc(100);
      cmp.power_on_request <= 1'b1;
      wt(MF, 0, 60);
   endtask

   task automatic t_regs();
      rd(4'h0, 32'h0);
      wr(4'h2, 32'hffffffff);
      rd(4'h2, 32'h0);
      wr(4'h0, 32'h08);
      rd(4'h0, 32'h08);
      chk("aux_thr", aux_thr_3v3, 32'h1);
      wr(4'h0, 32'h0);
      wt(TH, 0, 3);
      wr(4'hc, 32'h3f);
   endtask

   task automatic t_start();
      @(posedge mclk) cmp.supply_undervoltage_lockout <= 1'b0;
      cyc(100);
      #1 chk("aux uv early", aux_duty_pulldown, 32'h0);
      wt(DP, 1, 40);
      chk("mf aux uv", main_fault, 32'h1);
      @(posedge mclk) cmp.aux_uv <= 1'b0;
      wt(DP, 0, 10);
      @(posedge mclk) cmp.power_on_request <= 1'b1;
      cyc(15);
      #1 chk("pon early", main_fault, 32'h1);
      wt(MF, 0, 30);
      @(posedge mclk) cmp.uv[0] <= 1'b1;
      cyc(100);
      cmp.uv[0] <= 1'b0;
      #1 chk("uv blanked", main_fault, 32'h0);
      cyc(650);
      #1 chk("pg early", power_good, 32'h0);
      wt(PG, 1, 150);
      rd(4'h8, 32'h18);
      wt(IQ, 0, 3);
   endtask

   task automatic t_ov();
      restart();
      @(posedge mclk) cmp.ov[0] <= 1'b1;
      cyc(590);
      #1 chk("ov early", main_fault, 32'h0);
      wt(MF, 1, 20);
      wt(IQ, 1, 3);
      rd(4'h8, 32'h21);
      wt(IQ, 0, 3);
      @(posedge mclk) cmp.ov[0] <= 1'b0;
      cyc(400);
      #1 chk("ov latch", main_fault, 32'h1);
      restart();
      wt(PG, 1, 900);
   endtask

   task automatic t_ovdis();
      wr(4'h0, 32'h06);
      @(posedge mclk) cmp.ov <= 5'h0a;
      cyc(700);
      #1 chk("ov off", {main_fault, power_good}, 32'h1);
      @(posedge mclk) cmp.ov <= 5'h00;
      wr(4'h0, 32'h0);
   endtask

   task automatic t_uv();
      @(posedge mclk) cmp.uv[1] <= 1'b1;
      cyc(30);
      cmp.uv[1] <= 1'b0;
      cyc(20);
      #1 chk("uv5 short", main_fault, 32'h0);
      wt(PG, 1, 200);
      @(posedge mclk) cmp.uv[4] <= 1'b1;
      cyc(590);
      #1 chk("uv12 early", main_fault, 32'h0);
      wt(MF, 1, 20);
      chk("pg uv", power_good, 32'h0);
      @(posedge mclk) cmp.uv[4] <= 1'b0;
      cyc(1200);
      #1 chk("uv latch", main_fault, 32'h1);
      restart();
      wt(PG, 1, 900);
   endtask

   task automatic t_oc();
      wr(4'h0, 32'h11);
      @(posedge mclk) cmp.oc_5v <= 1'b1;
      cyc(100);
      cmp.oc_5v <= 1'b0;
      #1 chk("oc5 moved", main_fault, 32'h0);
      @(posedge mclk) cmp.oc_3v3 <= 1'b1;
      wt(MF, 1, 50);
      @(posedge mclk) cmp.oc_3v3 <= 1'b0;
      cyc(250);
      #1 chk("bounce wait", main_fault, 32'h1);
      wt(MF, 0, 100);
      wr(4'h0, 32'h0);
      wt(PG, 1, 900);
      @(posedge mclk) cmp.oc_12v <= 1'b1;
      wt(MF, 1, 50);
      @(posedge mclk) cmp.oc_12v <= 1'b0;
      restart();
      wt(PG, 1, 900);
   endtask

   task automatic t_off();
      @(posedge mclk) cmp.power_on_request <= 1'b0;
      cyc(10);
      cmp.power_on_request <= 1'b1;
      cyc(30);
      #1 chk("pon glitch", power_good, 32'h1);
      @(posedge mclk) cmp.power_on_request <= 1'b0;
      wt(PG, 0, 30);
      chk("warn mf", main_fault, 32'h0);
      wt(MF, 1, 40);
      @(posedge mclk) cmp.power_on_request <= 1'b1;
      wt(MF, 0, 60);
      wt(PG, 1, 900);
   endtask

   task automatic t_mains();
      @(posedge mclk) cmp.mains_ok <= 1'b0;
      wt(PG, 0, 5);
      chk("mf mains", main_fault, 32'h0);
      @(posedge mclk) cmp.mains_ok <= 1'b1;
      cyc(50);
      #1 chk("pg delay", power_good, 32'h0);
      wt(PG, 1, 80);
   endtask

   // A low enable must hold power_good, even across a mains fault
   task automatic t_ce();
      @(posedge mclk) ce <= 1'b0;
      cmp.mains_ok <= 1'b0;
      cyc(10);
      #1 chk("ce freeze", power_good, 32'h1);
      @(posedge mclk) ce <= 1'b1;
      wt(PG, 0, 5);
      @(posedge mclk) cmp.mains_ok <= 1'b1;
      wt(PG, 1, 120);
   endtask

   task automatic t_auxov();
      @(posedge mclk) cmp.aux_ov <= 1'b1;
      cyc(590);
      #1 chk("aux ov early", aux_fault, 32'h0);
      wt(AF, 1, 20);
      wt(MF, 1, 3);
      @(posedge mclk) cmp.aux_ov <= 1'b0;
      cmp.power_on_request <= 1'b0;
      cyc(100);
      cmp.power_on_request <= 1'b1;
      cyc(100);
      #1 chk("aux latch", {aux_fault, main_fault}, 32'h3);
      @(posedge mclk) cmp.supply_undervoltage_lockout <= 1'b1;
      cyc(5);
      cmp.supply_undervoltage_lockout <= 1'b0;
      wt(AF, 0, 3);
      cyc(10);
      #1 chk("deb reset", main_fault, 32'h1);
      wt(MF, 0, 60);
   endtask

   task automatic summarize();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      arst_n = 1'b0;
      ce = 1'b1;
      cmp = '0;
      cmp.supply_undervoltage_lockout = 1'b1;
      cmp.mains_ok = 1'b1;
      cmp.aux_uv = 1'b1;
      addr = 4'h0;
      wr_data = 32'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      cyc(6);
      #1 chk("rst mf", main_fault, 32'h1);
      @(posedge mclk) arst_n <= 1'b1;
      t_regs();
      t_start();
      t_ov();
      t_ovdis();
      t_uv();
      t_oc();
      t_off();
      t_mains();
      t_ce();
      t_auxov();
      summarize();
   end

   // The sequence needs about 11k cycles; this leaves ample margin
   initial begin
      #400us;
      miscompares++;
      summarize();
   end
endmodule // psu_fault_supervisor_tb
